// ### isu_subtract_unit.sv
// Integer subtract-from datapath with exception flags, condition field zero,
// a small register port and a level interrupt.
// Assumes operation requests come from logic on clk_sys, one per cycle at most.
//
// Function
// - Every form subtracts the first source from the second source, the immediate or a constant, never the reverse.
// - Plain and carrying forms write the complement of the first source plus the second plus one.
// - The immediate is sign-extended to 32 bits and the immediate form also updates carry.
// - The plain form without record or overflow writes only the destination.
// - Record variants update condition field zero from the result.
// - Overflow variants of the plain form update overflow and summary overflow.
// - Carrying forms write the carry-out into the carry flag as well as the sum.
// - Carrying or extended forms with overflow update carry, overflow and summary together.
// - Extended forms add complement of first source, second source and incoming carry.
// - Minus-one-extended forms add complement, incoming carry and all ones, updating carry.
// - Zero-extended forms add complement and incoming carry, updating carry.
// - A carrying low-word step chained with an extended high-word step gives a wide difference.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module isu_subtract_unit #(
  parameter int unsigned XLEN     = isu_pkg::ISU_XLEN,
  parameter int unsigned IMM_LEN  = isu_pkg::ISU_IMM_LEN,
  parameter int unsigned ADDR_LEN = isu_pkg::ISU_ADDR_LEN
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      clk_en,
  input  wire logic                      op_valid,
  input  wire isu_pkg::isu_form_t        op_form,
  input  wire logic                      op_record,
  input  wire logic                      op_overflow,
  input  wire logic [XLEN-1:0]           first_source_reg,
  input  wire logic [XLEN-1:0]           second_source_reg,
  input  wire logic [IMM_LEN-1:0]        signed_immediate,
  input  wire logic [ADDR_LEN-1:0]       reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [31:0]               reg_rdata,
  output logic                           result_valid,
  output logic      [XLEN-1:0]           result,
  output logic                           carry_flag,
  output logic                           overflow_flag,
  output logic                           summary_overflow_flag,
  output logic      [isu_pkg::ISU_CR_LEN-1:0] cond_field_zero,
  output logic                           irq
);

  // ------------------------------------------------------------------
  // Form decoding
  // ------------------------------------------------------------------
  function automatic logic form_sets_carry(input isu_pkg::isu_form_t f);
    return (f != isu_pkg::ISU_PLAIN);
  endfunction

  // Immediate form has no record or overflow variant
  function automatic logic form_has_variants(input isu_pkg::isu_form_t f);
    return (f != isu_pkg::ISU_IMMEDIATE);
  endfunction

  // ------------------------------------------------------------------
  // Adder
  // ------------------------------------------------------------------
  logic [XLEN-1:0] addend_a;
  logic [XLEN-1:0] addend_b;
  logic            carry_in;
  logic [XLEN:0]   sum_full;
  logic            signed_ovf;
  logic            op_take;
  logic            upd_carry;
  logic            upd_ovf;
  logic            upd_cond;

  always_comb begin
    addend_a = ~first_source_reg;
    addend_b = second_source_reg;
    carry_in = 1'b1;
    unique case (op_form)
      isu_pkg::ISU_PLAIN,
      isu_pkg::ISU_CARRYING: carry_in = 1'b1;
      isu_pkg::ISU_IMMEDIATE: begin
        addend_b = {{(XLEN-IMM_LEN){signed_immediate[IMM_LEN-1]}}, signed_immediate};
        carry_in = 1'b1;
      end
      isu_pkg::ISU_EXTENDED: begin
        addend_b = second_source_reg;
        carry_in = carry_flag;
      end
      isu_pkg::ISU_MINUS_ONE: begin
        addend_b = isu_pkg::ISU_ALL_ONES[XLEN-1:0];
        carry_in = carry_flag;
      end
      isu_pkg::ISU_ZERO_EXT: begin
        addend_b = isu_pkg::ISU_ZERO[XLEN-1:0];
        carry_in = carry_flag;
      end
      default: ;
    endcase
  end

  // Carry in is a full 33-bit term so the carry-out is exact for every form
  assign sum_full   = {1'b0, addend_a} + {1'b0, addend_b} + {{XLEN{1'b0}}, carry_in};
  assign signed_ovf = (addend_a[XLEN-1] == addend_b[XLEN-1])
                   && (sum_full[XLEN-1] != addend_a[XLEN-1]);

  assign op_take   = clk_en && op_valid;
  assign upd_carry = form_sets_carry(op_form);
  assign upd_ovf   = op_overflow && form_has_variants(op_form);
  assign upd_cond  = op_record && form_has_variants(op_form);

  // ------------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------------
  logic wr_exc;
  logic wr_clear;
  logic wr_enable;

  assign wr_exc    = clk_en && reg_write && (reg_addr == isu_pkg::ISU_REG_EXC);
  assign wr_clear  = clk_en && reg_write && (reg_addr == isu_pkg::ISU_REG_IRQ_CLEAR);
  assign wr_enable = clk_en && reg_write && (reg_addr == isu_pkg::ISU_REG_IRQ_ENABLE);

  // ------------------------------------------------------------------
  // Destination
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result       <= isu_pkg::ISU_RST_WORD[XLEN-1:0];
      result_valid <= 1'b0;
    end else if (clk_en) begin
      result_valid <= op_valid;
      if (op_valid) begin
        result <= sum_full[XLEN-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Exception flags
  // ------------------------------------------------------------------
  logic next_carry;
  logic next_ovf;
  logic next_summary;

  // Hardware update beats a software write of the same field in one cycle
  always_comb begin
    next_carry   = wr_exc ? reg_wdata[isu_pkg::ISU_EXC_CARRY] : carry_flag;
    next_ovf     = wr_exc ? reg_wdata[isu_pkg::ISU_EXC_OVF] : overflow_flag;
    next_summary = wr_exc ? reg_wdata[isu_pkg::ISU_EXC_SO] : summary_overflow_flag;
    if (op_take && upd_carry) begin
      next_carry = sum_full[XLEN];
    end
    if (op_take && upd_ovf) begin
      next_ovf = signed_ovf;
      if (signed_ovf) begin
        next_summary = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      carry_flag            <= 1'b0;
      overflow_flag         <= 1'b0;
      summary_overflow_flag <= 1'b0;
    end else if (clk_en) begin
      carry_flag            <= next_carry;
      overflow_flag         <= next_ovf;
      summary_overflow_flag <= next_summary;
    end
  end

  // ------------------------------------------------------------------
  // Condition field zero
  // ------------------------------------------------------------------
  logic [isu_pkg::ISU_CR_LEN-1:0] next_cond;

  always_comb begin
    next_cond = '0;
    next_cond[isu_pkg::ISU_CR_LT] = sum_full[XLEN-1];
    next_cond[isu_pkg::ISU_CR_GT] = !sum_full[XLEN-1] && (sum_full[XLEN-1:0] != '0);
    next_cond[isu_pkg::ISU_CR_EQ] = (sum_full[XLEN-1:0] == '0);
    next_cond[isu_pkg::ISU_CR_SO] = next_summary;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cond_field_zero <= isu_pkg::ISU_RST_COND;
    end else if (op_take && upd_cond) begin
      cond_field_zero <= next_cond;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [isu_pkg::ISU_EV_LEN-1:0] irq_status;
  logic [isu_pkg::ISU_EV_LEN-1:0] irq_enable;
  logic [isu_pkg::ISU_EV_LEN-1:0] irq_event;

  assign irq_event[isu_pkg::ISU_EV_DONE]     = op_take;
  assign irq_event[isu_pkg::ISU_EV_OVERFLOW] = op_take && upd_ovf && signed_ovf;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status <= isu_pkg::ISU_RST_EV;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~(wr_clear ? reg_wdata[isu_pkg::ISU_EV_LEN-1:0] : '0))
                  | irq_event;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_enable <= isu_pkg::ISU_RST_EV;
    end else if (wr_enable) begin
      irq_enable <= reg_wdata[isu_pkg::ISU_EV_LEN-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [31:0] read_word;

  // Unmapped and write-only offsets read as zero
  always_comb begin
    read_word = '0;
    unique case (reg_addr)
      isu_pkg::ISU_REG_EXC: begin
        read_word[isu_pkg::ISU_EXC_SO] = summary_overflow_flag;
        read_word[isu_pkg::ISU_EXC_OVF] = overflow_flag;
        read_word[isu_pkg::ISU_EXC_CARRY] = carry_flag;
      end
      isu_pkg::ISU_REG_COND:       read_word[isu_pkg::ISU_CR_LEN-1:0] = cond_field_zero;
      isu_pkg::ISU_REG_RESULT:     read_word[XLEN-1:0] = result;
      isu_pkg::ISU_REG_IRQ_STATUS: read_word[isu_pkg::ISU_EV_LEN-1:0] = irq_status;
      isu_pkg::ISU_REG_IRQ_ENABLE: read_word[isu_pkg::ISU_EV_LEN-1:0] = irq_enable;
      default:                     read_word = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= isu_pkg::ISU_RST_WORD;
    end else if (clk_en) begin
      reg_rdata <= reg_read ? read_word : isu_pkg::ISU_RST_WORD;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence low_word_step;
    op_take && op_form == isu_pkg::ISU_CARRYING;
  endsequence

  sequence high_word_step;
    op_take && op_form == isu_pkg::ISU_EXTENDED;
  endsequence

  plain_diff_a: assert property (
    op_take && op_form == isu_pkg::ISU_PLAIN
    |=> result == $past(second_source_reg) - $past(first_source_reg))
    else $error("plain form result is not second minus first");

  imm_diff_a: assert property (
    op_take && op_form == isu_pkg::ISU_IMMEDIATE
    |=> result == XLEN'($signed($past(signed_immediate))) - $past(first_source_reg)
        && carry_flag == (XLEN'($signed($past(signed_immediate))) >= $past(first_source_reg)))
    else $error("immediate form result or carry wrong");

  plain_quiet_a: assert property (
    op_take && op_form == isu_pkg::ISU_PLAIN && !op_record && !op_overflow && !reg_write
    |=> $stable(carry_flag) && $stable(overflow_flag) && $stable(summary_overflow_flag)
        && $stable(cond_field_zero))
    else $error("plain form changed flags");

  record_eq_a: assert property (
    op_take && op_record && op_form != isu_pkg::ISU_IMMEDIATE
    |=> cond_field_zero[isu_pkg::ISU_CR_EQ] == (result == '0)
        && cond_field_zero[isu_pkg::ISU_CR_LT] == result[XLEN-1])
    else $error("condition field does not match result");

  record_so_a: assert property (
    op_take && op_record && op_form != isu_pkg::ISU_IMMEDIATE
    |=> cond_field_zero[isu_pkg::ISU_CR_SO] == summary_overflow_flag)
    else $error("condition field summary bit not copied");

  ovf_sticky_a: assert property (
    op_take && upd_ovf && signed_ovf
    |=> overflow_flag && summary_overflow_flag ##1 (summary_overflow_flag || $past(wr_exc)))
    else $error("overflow did not set both flags");

  carry_out_a: assert property (
    op_take && op_form == isu_pkg::ISU_CARRYING
    |=> carry_flag == ($past(second_source_reg) >= $past(first_source_reg)))
    else $error("carrying form carry flag wrong");

  extended_sum_a: assert property (
    op_take && op_form == isu_pkg::ISU_EXTENDED
    |=> result == ~$past(first_source_reg) + $past(second_source_reg)
                  + XLEN'($past(carry_flag)))
    else $error("extended form result wrong");

  minus_one_a: assert property (
    op_take && op_form == isu_pkg::ISU_MINUS_ONE
    |=> result == ~$past(first_source_reg) + XLEN'($past(carry_flag)) - XLEN'(1))
    else $error("minus-one form result wrong");

  zero_ext_a: assert property (
    op_take && op_form == isu_pkg::ISU_ZERO_EXT
    |=> result == ~$past(first_source_reg) + XLEN'($past(carry_flag))
        && carry_flag == ($past(first_source_reg) == '0 && $past(carry_flag)))
    else $error("zero form result or carry wrong");

  chain_wide_a: assert property (
    low_word_step ##1 high_word_step
    |=> result == $past(second_source_reg) - $past(first_source_reg)
                  - XLEN'($past(second_source_reg, 2) < $past(first_source_reg, 2))
        && carry_flag == ({$past(second_source_reg), $past(second_source_reg, 2)}
                          >= {$past(first_source_reg), $past(first_source_reg, 2)}))
    else $error("chained subtraction lost the borrow");

  irq_done_a: assert property (
    op_take |=> irq_status[isu_pkg::ISU_EV_DONE])
    else $error("operation did not set its done status bit");

endmodule

`default_nettype wire

// ### isu_pkg.sv
// Constants, register map and operation forms of the integer subtract unit.
// Assumes a 32-bit datapath and a plain byte-addressed register port.
package isu_pkg;

  // ------------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------------
  localparam int unsigned ISU_XLEN     = 32;
  localparam int unsigned ISU_IMM_LEN  = 16;
  localparam int unsigned ISU_ADDR_LEN = 8;
  localparam logic [31:0] ISU_ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] ISU_ZERO     = 32'h00000000;

  // Operation form; each one fixes the second addend and the carry-in
  typedef enum logic [2:0] {
    ISU_PLAIN,
    ISU_CARRYING,
    ISU_IMMEDIATE,
    ISU_EXTENDED,
    ISU_MINUS_ONE,
    ISU_ZERO_EXT
  } isu_form_t;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ISU_REG_EXC        = 8'h00;
  localparam logic [7:0] ISU_REG_COND       = 8'h04;
  localparam logic [7:0] ISU_REG_RESULT     = 8'h08;
  localparam logic [7:0] ISU_REG_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ISU_REG_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] ISU_REG_IRQ_ENABLE = 8'h14;

  // Exception register fields
  localparam int unsigned ISU_EXC_SO    = 31;
  localparam int unsigned ISU_EXC_OVF   = 30;
  localparam int unsigned ISU_EXC_CARRY = 29;

  // Condition field bits
  localparam int unsigned ISU_CR_LT = 3;
  localparam int unsigned ISU_CR_GT = 2;
  localparam int unsigned ISU_CR_EQ = 1;
  localparam int unsigned ISU_CR_SO = 0;
  localparam int unsigned ISU_CR_LEN = 4;

  // Interrupt event bits
  localparam int unsigned ISU_EV_DONE     = 0;
  localparam int unsigned ISU_EV_OVERFLOW = 1;
  localparam int unsigned ISU_EV_LEN      = 2;

  // Reset values
  localparam logic [31:0] ISU_RST_WORD = 32'h00000000;
  localparam logic [3:0]  ISU_RST_COND = 4'h0;
  localparam logic [1:0]  ISU_RST_EV   = 2'h0;

endpackage

// ### tb.sv
// Self-checking bench of the integer subtract unit: random and corner operations,
// register port, interrupt. Assumes isu_pkg and isu_subtract_unit compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  logic               clk_en = 1'b1;
  logic               op_valid = 1'b0;
  isu_pkg::isu_form_t op_form = isu_pkg::ISU_PLAIN;
  logic               op_record = 1'b0;
  logic               op_overflow = 1'b0;
  logic [31:0]        first_source_reg = 32'h0;
  logic [31:0]        second_source_reg = 32'h0;
  logic [15:0]        signed_immediate = 16'h0;
  logic [7:0]         reg_addr = 8'h0;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_write = 1'b0;
  logic               reg_read = 1'b0;
  logic [31:0]        reg_rdata;
  logic               result_valid;
  logic [31:0]        result;
  logic               carry_flag;
  logic               overflow_flag;
  logic               summary_overflow_flag;
  logic [3:0]         cond_field_zero;
  logic               irq;
  logic               m_carry, m_ovf, m_so;
  logic [3:0]         m_cond;
  logic [31:0]        m_res, lo, seed = 32'h781E;
  logic [63:0]        iw, jw;
  int                 bad_count = 0, checked = 0, cycles = 0;
  logic [7:0]         addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [31:0]        edge_val [4] = '{32'h0, 32'hFFFFFFFF, 32'h80000000, 32'h7FFFFFFF};

  isu_subtract_unit u_isu_subtract_unit (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .op_valid(op_valid),
    .op_form(op_form), .op_record(op_record), .op_overflow(op_overflow),
    .first_source_reg(first_source_reg), .second_source_reg(second_source_reg),
    .signed_immediate(signed_immediate), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .result_valid(result_valid), .result(result), .carry_flag(carry_flag),
    .overflow_flag(overflow_flag), .summary_overflow_flag(summary_overflow_flag),
    .cond_field_zero(cond_field_zero), .irq(irq)
  );

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Overflow from carry into and out of the sign bit, so carry-in counts too
  function automatic logic [33:0] add_ov(input logic [31:0] x, y, input logic cin);
    logic [32:0] s;
    logic [31:0] l;
    s = {1'b0, x} + {1'b0, y} + 33'(cin);
    l = {1'b0, x[30:0]} + {1'b0, y[30:0]} + 32'(cin);
    return {l[31] ^ s[32], s};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask

  task automatic op(input isu_pkg::isu_form_t f, input logic rec, ovf,
                    input logic [31:0] a, b, input logic [15:0] imm);
    logic [31:0] y;
    logic        cin;
    logic [33:0] r;
    logic        tk;
    y = b;
    cin = 1'b1;
    case (f)
      isu_pkg::ISU_IMMEDIATE: y = {{16{imm[15]}}, imm};
      isu_pkg::ISU_EXTENDED:  cin = m_carry;
      isu_pkg::ISU_MINUS_ONE: begin
        y = isu_pkg::ISU_ALL_ONES;
        cin = m_carry;
      end
      isu_pkg::ISU_ZERO_EXT: begin
        y = isu_pkg::ISU_ZERO;
        cin = m_carry;
      end
      default: ;
    endcase
    r = add_ov(~a, y, cin);
    tk = (f != isu_pkg::ISU_IMMEDIATE);
    if (f != isu_pkg::ISU_PLAIN) m_carry = r[32];
    if (ovf && tk) begin
      m_ovf = r[33];
      m_so = m_so | r[33];
    end
    if (rec && tk) m_cond = {r[31], !r[31] && r[31:0] != 0, r[31:0] == 0, m_so};
    m_res = r[31:0];
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_form <= f;
    op_record <= rec;
    op_overflow <= ovf;
    first_source_reg <= a;
    second_source_reg <= b;
    signed_immediate <= imm;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    check(result_valid, 1);
    check(result, m_res);
    check(carry_flag, m_carry);
    check({overflow_flag, summary_overflow_flag}, {m_ovf, m_so});
    check(cond_field_zero, m_cond);
  endtask

  // Back-to-back pair, so the extended step uses the carry of the step just before
  task automatic chain(input logic [63:0] i, j);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_form <= isu_pkg::ISU_CARRYING;
    op_record <= 1'b0;
    op_overflow <= 1'b0;
    first_source_reg <= j[31:0];
    second_source_reg <= i[31:0];
    @(posedge clk_sys);
    op_form <= isu_pkg::ISU_EXTENDED;
    first_source_reg <= j[63:32];
    second_source_reg <= i[63:32];
    #1;
    check(result, 32'(i - j));
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    m_carry = (i >= j);
    m_res = 32'((i - j) >> 32);
    check(result, m_res);
    check(carry_flag, m_carry);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] a;
    {m_carry, m_ovf, m_so, m_cond, m_res} = '0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    check({result, cond_field_zero, irq, result_valid}, 0);
    foreach (addrs[k]) rd(addrs[k], 0);
    $display("test reset done");
    op(isu_pkg::ISU_PLAIN, 1, 1, 32'h1, 32'h80000000, 0);
    op(isu_pkg::ISU_PLAIN, 1, 1, 32'h1, 32'h2, 0);
    op(isu_pkg::ISU_PLAIN, 0, 0, 32'h5, 32'h3, 0);
    rd(isu_pkg::ISU_REG_EXC, {m_so, m_ovf, m_carry, 29'h0});
    wr(isu_pkg::ISU_REG_EXC, 32'h20000000);
    {m_so, m_ovf, m_carry} = 3'h1;
    rd(isu_pkg::ISU_REG_EXC, 32'h20000000);
    op(isu_pkg::ISU_ZERO_EXT, 1, 1, 32'hFFFFFFFF, 0, 0);
    $display("test flags done");
    for (int k = 0; k < 4; k++) begin
      iw = {rnd(), (k == 0) ? 32'h0 : rnd()};
      jw = {rnd(), (k == 0) ? 32'h1 : rnd()};
      op(isu_pkg::ISU_CARRYING, 0, 0, jw[31:0], iw[31:0], 0);
      lo = result;
      op(isu_pkg::ISU_EXTENDED, 0, 0, jw[63:32], iw[63:32], 0);
      check(lo, 32'(iw - jw));
      check(result, 32'((iw - jw) >> 32));
      chain(iw, jw);
    end
    $display("test multiword done");
    for (int k = 0; k < 300; k++) begin
      a = (k % 4 == 0) ? edge_val[(k / 4) % 4] : rnd();
      op(isu_pkg::isu_form_t'(3'(rnd() % 6)), 1'(rnd()), 1'(rnd()), a, rnd(), 16'(rnd()));
      check(irq, 0);
      if (k % 32 == 0) begin
        rd(isu_pkg::ISU_REG_RESULT, m_res);
        rd(isu_pkg::ISU_REG_COND, {28'h0, m_cond});
      end
    end
    $display("test random done");
    @(posedge clk_sys);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    first_source_reg <= rnd();
    @(posedge clk_sys);
    clk_en <= 1'b1;
    op_valid <= 1'b0;
    #1;
    check({result_valid, result}, {1'b0, m_res});
    $display("test clock enable done");
    wr(isu_pkg::ISU_REG_IRQ_CLEAR, 32'h3);
    wr(isu_pkg::ISU_REG_IRQ_ENABLE, 32'h3);
    rd(isu_pkg::ISU_REG_IRQ_STATUS, 0);
    check(irq, 0);
    op(isu_pkg::ISU_PLAIN, 0, 1, 32'h1, 32'h80000000, 0);
    rd(isu_pkg::ISU_REG_IRQ_STATUS, 32'h3);
    check(irq, 1);
    wr(isu_pkg::ISU_REG_IRQ_CLEAR, 32'h1);
    rd(isu_pkg::ISU_REG_IRQ_STATUS, 32'h2);
    check(irq, 1);
    wr(isu_pkg::ISU_REG_IRQ_ENABLE, 32'h1);
    check(irq, 0);
    rd(isu_pkg::ISU_REG_IRQ_ENABLE, 32'h1);
    rd(isu_pkg::ISU_REG_IRQ_CLEAR, 0);
    wr(isu_pkg::ISU_REG_IRQ_CLEAR, 32'h2);
    rd(isu_pkg::ISU_REG_IRQ_STATUS, 0);
    $display("test interrupt done");
    end_of_test();
  end
endmodule

`default_nettype wire
